// ### hw/async_serial_transceiver.sv
// Function
// - Words are 8 bits with word9 clear, 9 bits with it set.
// - Transmit pin low for start bit, high for stop bit.
// - Idle character is one whole frame of ones.
// - Break frames repeat while requested, then one extra one bit.
// - Transmit and receive each have their own baud generator.
// - Ninth transmitted bit comes from tx_ninth.
// - Data leaves LSB first through a holding buffer.
// - Enabling transmitter takes the pin and sends an idle frame first.
// - Empty and done flags clear by flag access then data write.
// - Write during a frame waits in holding buffer until frame ends.
// - Write while idle starts at once and sets empty.
// - Frame end sets done flag with its gated interrupt.
// - Empty flag requests an interrupt when enabled and unmasked.
// - Disabling transmitter drops held data; re-enabling queues idle frame.
// - Receiver shifts LSB first; ninth bit goes to rx_ninth.
// - Enabling receiver starts the hunt for a start bit.
// - Completed character fills holding buffer and sets full flag.
// - Full flag clears by flag access then data read.
// - Idle frame acts as a character plus the idle interrupt.
// - Character on full buffer sets overrun and keeps held data.
// - Noise sets noise flag with full flag, no own interrupt.
// - Missing stop bit or break sets framing flag with full flag.
// - Rate is clock over 16 times coarse factor times 2 power ratio.
//
// The Wishbone register port and the register addresses were chosen for this implementation.
`timescale 1ns/10ps
`include "async_serial_map.svh"

module async_serial_transceiver
(
   // Clock and reset.
   input  wire logic                    clk_sys,
   input  wire logic                    resetn,
   // Register bus.
   input  wire async_serial_pkg::wb_req_t wb_req,
   output      async_serial_pkg::wb_rsp_t wb_rsp,
   // Processor global interrupt mask, high masks all requests.
   input  wire logic                    irq_mask,
   output      logic                    irq_req,
   // Serial line.
   input  wire logic                    serial_rx_pin,
   output      logic                    tx_pin,
   output      logic                    tx_oe
);
   import async_serial_pkg::*;

   ////////////////////////////////////////////////////////////////////////
   // Reset release through two flip-flops.
   logic    rst_meta;
   logic    rst_n;
   state_t  s;
   state_t  next_s;

   always_ff @(posedge clk_sys or negedge resetn)
   begin
      if (!resetn)
      begin
         rst_meta <= 1'b0;
         rst_n    <= 1'b0;
      end
      else
      begin
         rst_meta <= 1'b1;
         rst_n    <= rst_meta;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Cycles per sixteenth of a bit, less one.
   function automatic logic [10:0] div_load(input logic [1:0] sel, input logic [2:0] ratio);
      logic [10:0] f;
      f = `COARSE_0;
      unique case (sel)
         2'h0: f = `COARSE_0;
         2'h1: f = `COARSE_1;
         2'h2: f = `COARSE_2;
         2'h3: f = `COARSE_3;
      endcase
      return 11'((f << ratio) - 11'h001);
   endfunction : div_load

   ////////////////////////////////////////////////////////////////////////
   // Next state.
   logic        acc;
   logic        req;
   logic        tx_tick;
   logic        rx_tick;
   logic        tx_free;
   logic        bit_val;
   logic [3:0]  frame_bits;
   logic [7:0]  idle_len;
   logic [8:0]  word;
   logic        rx_done;
   logic        rx_idle_ev;
   logic        rx_frame_err;

   always_comb
   begin
      next_s       = s;
      acc          = wb_req.cyc && wb_req.stb && s.ack;
      req          = wb_req.cyc && wb_req.stb && !s.ack;
      frame_bits   = s.word9 ? 4'hb : 4'ha;
      idle_len     = s.word9 ? 8'hb0 : 8'ha0;
      tx_free      = 1'b0;
      bit_val      = 1'b0;
      word         = 9'h000;
      rx_done      = 1'b0;
      rx_idle_ev   = 1'b0;
      rx_frame_err = 1'b0;

      // Independent sixteenth-bit dividers for each direction.
      tx_tick = (s.tx_div == 11'h000);
      rx_tick = (s.rx_div == 11'h000);
      next_s.tx_div = tx_tick ? div_load(s.baud[`BR_COARSE_LSB +: 2], s.baud[`BR_TX_LSB +: 3])
                              : 11'(s.tx_div - 11'h001);
      next_s.rx_div = rx_tick ? div_load(s.baud[`BR_COARSE_LSB +: 2], s.baud[`BR_RX_LSB +: 3])
                              : 11'(s.rx_div - 11'h001);

      // Pin synchroniser; the line moves once stages two and three agree.
      next_s.rx_pin = {s.rx_pin[1:0], serial_rx_pin};
      if (s.rx_pin[1] == s.rx_pin[2])
         next_s.rx_line = s.rx_pin[2];

      ///////////////////////////////////////////////////////////////////
      // Transmitter bit timing.
      if (s.tx_st != TX_IDLE && tx_tick)
      begin
         next_s.tx_sub = 4'(s.tx_sub + 4'h1);
         if (s.tx_sub == `SUB_LAST)
         begin
            next_s.tx_sh   = {1'b1, s.tx_sh[10:1]};
            next_s.tx_bits = 4'(s.tx_bits - 4'h1);
            if (s.tx_bits == 4'h1)
            begin
               tx_free = 1'b1;
               if (s.tx_st != TX_MARK)
                  next_s.done = 1'b1;
            end
         end
      end
      if (s.tx_st == TX_IDLE)
         tx_free = 1'b1;

      // Pick the next frame once the line is free.
      if (tx_free)
      begin
         next_s.tx_st  = TX_IDLE;
         next_s.tx_sub = 4'h0;
         if (s.tx_on && s.idle_pend)
         begin
            next_s.tx_sh     = 11'h7ff;
            next_s.tx_bits   = frame_bits;
            next_s.tx_st     = TX_SEND;
            next_s.idle_pend = 1'b0;
         end
         else if (s.tx_on && s.brk)
         begin
            next_s.tx_sh   = 11'h000;
            next_s.tx_bits = frame_bits;
            next_s.tx_st   = TX_BRK;
         end
         else if (s.tx_st == TX_BRK)
         begin
            next_s.tx_sh   = 11'h7ff;
            next_s.tx_bits = 4'h1;
            next_s.tx_st   = TX_MARK;
         end
         else if (s.tx_on && s.hold_valid)
         begin
            // Start low, data LSB first, optional ninth, stop high.
            next_s.tx_sh = s.word9 ? {1'b1, s.tx_ninth, s.hold, 1'b0}
                                   : {2'b11, s.hold, 1'b0};
            next_s.tx_bits    = frame_bits;
            next_s.tx_st      = TX_SEND;
            next_s.hold_valid = 1'b0;
            next_s.empty      = 1'b1;
         end
      end

      ///////////////////////////////////////////////////////////////////
      // Receiver: hunt, then sample each bit at sixteenths 7, 8 and 9.
      if (!s.rx_on)
      begin
         next_s.rx_st = RX_HUNT;
      end
      else if (rx_tick)
      begin
         unique case (s.rx_st)
            RX_HUNT:
            begin
               if (!s.rx_line)
               begin
                  next_s.rx_st    = RX_BITS;
                  next_s.rx_sub   = 4'h1;
                  next_s.rx_idx   = 4'h0;
                  next_s.rx_noise = 1'b0;
                  next_s.idle_cnt = 8'h00;
               end
               else if (s.idle_arm)
               begin
                  next_s.idle_cnt = 8'(s.idle_cnt + 8'h01);
                  if (s.idle_cnt == 8'(idle_len - 8'h01))
                  begin
                     rx_idle_ev      = 1'b1;
                     next_s.idle_arm = 1'b0;
                  end
               end
            end
            RX_BITS:
            begin
               next_s.rx_sub = 4'(s.rx_sub + 4'h1);
               if (s.rx_sub == `SUB_SMP_A)
                  next_s.smp[0] = s.rx_line;
               if (s.rx_sub == `SUB_SMP_B)
                  next_s.smp[1] = s.rx_line;
               if (s.rx_sub == `SUB_DECIDE)
               begin
                  bit_val = (s.smp[0] & s.smp[1]) | (s.smp[0] & s.rx_line)
                          | (s.smp[1] & s.rx_line);
                  if (!(s.smp[0] == s.rx_line && s.smp[1] == s.rx_line))
                     next_s.rx_noise = 1'b1;
                  next_s.rx_idx = 4'(s.rx_idx + 4'h1);
                  if (s.rx_idx == 4'h0 && bit_val)
                     next_s.rx_st = RX_HUNT;
                  else if (s.rx_idx == 4'(frame_bits - 4'h1))
                  begin
                     rx_done         = 1'b1;
                     rx_frame_err    = !bit_val;
                     next_s.rx_st    = RX_HUNT;
                     next_s.idle_arm = 1'b1;
                  end
                  else if (s.rx_idx != 4'h0)
                     next_s.rx_sh = {bit_val, s.rx_sh[8:1]};
               end
            end
            default:
               next_s.rx_st = RX_HUNT;
         endcase
      end

      ///////////////////////////////////////////////////////////////////
      // Bus: answer one cycle after the request, effects at the ack edge.
      next_s.ack = req;
      if (req)
      begin
         next_s.rdata = 32'h0000_0000;
         unique case (wb_req.adr)
            `OFS_FLAG:
               next_s.rdata[7:0] = {s.empty, s.done, s.full, s.idle, s.ovr,
                                    s.noise, s.framing, 1'b0};
            `OFS_DATA:
               next_s.rdata[7:0] = s.rx_hold[7:0];
            `OFS_CTRL_ONE:
               next_s.rdata[7:0] = {s.rx_ninth, s.tx_ninth, 1'b0, s.word9, 4'h0};
            `OFS_CTRL_TWO:
               next_s.rdata[7:0] = {s.irq_en, s.tx_on, s.rx_on, 1'b0, s.brk};
            `OFS_BAUD:
               next_s.rdata[7:0] = s.baud;
            default:
               next_s.rdata = 32'h0000_0000;
         endcase
      end
      if (acc && wb_req.adr == `OFS_FLAG)
      begin
         next_s.tx_arm = 1'b1;
         next_s.rx_arm = 1'b1;
      end
      if (acc && wb_req.adr == `OFS_DATA)
      begin
         if (wb_req.we && wb_req.sel[0])
         begin
            next_s.hold       = wb_req.dat[7:0];
            next_s.hold_valid = 1'b1;
            if (s.tx_arm)
            begin
               next_s.empty = 1'b0;
               next_s.done  = tx_free && s.tx_st != TX_IDLE && s.tx_st != TX_MARK;
            end
            next_s.tx_arm = 1'b0;
         end
         if (!wb_req.we)
         begin
            if (s.rx_arm)
            begin
               next_s.full    = 1'b0;
               next_s.ovr     = 1'b0;
               next_s.noise   = 1'b0;
               next_s.framing = 1'b0;
               next_s.idle    = 1'b0;
            end
            next_s.rx_arm = 1'b0;
         end
      end
      if (acc && wb_req.we && wb_req.sel[0])
      begin
         if (wb_req.adr == `OFS_CTRL_ONE)
         begin
            next_s.tx_ninth = wb_req.dat[`C1_TX_NINTH];
            next_s.word9    = wb_req.dat[`C1_WORD9];
         end
         if (wb_req.adr == `OFS_CTRL_TWO)
         begin
            next_s.irq_en = wb_req.dat[`C2_EMPTY_EN -: 4];
            next_s.tx_on  = wb_req.dat[`C2_TX_ON];
            next_s.rx_on  = wb_req.dat[`C2_RX_ON];
            next_s.brk    = wb_req.dat[`C2_BREAK];
            if (wb_req.dat[`C2_TX_ON] && !s.tx_on)
               next_s.idle_pend = 1'b1;
            if (!wb_req.dat[`C2_TX_ON])
               next_s.hold_valid = 1'b0;
            if (wb_req.dat[`C2_RX_ON] && !s.rx_on)
            begin
               next_s.idle_arm = 1'b1;
               next_s.idle_cnt = 8'h00;
            end
         end
         if (wb_req.adr == `OFS_BAUD)
            next_s.baud = wb_req.dat[7:0];
      end

      ///////////////////////////////////////////////////////////////////
      // Character completion; hardware sets win over the clear above.
      word = s.word9 ? s.rx_sh : {1'b0, s.rx_sh[8:1]};
      if (rx_done || rx_idle_ev)
      begin
         if (s.full)
            next_s.ovr = 1'b1;
         else
         begin
            next_s.rx_hold  = rx_idle_ev ? 9'h1ff : word;
            next_s.rx_ninth = rx_idle_ev ? 1'b1 : word[8];
            next_s.full     = 1'b1;
            next_s.noise    = rx_done && s.rx_noise | next_s.rx_noise;
            next_s.framing  = rx_frame_err;
            next_s.idle     = rx_idle_ev;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // State register.
   always_ff @(posedge clk_sys or negedge rst_n)
   begin
      if (!rst_n)
      begin
         s          <= '0;
         s.tx_st    <= TX_IDLE;
         s.rx_st    <= RX_HUNT;
         s.empty    <= `RST_EMPTY;
         s.done     <= `RST_DONE;
         s.baud     <= `RST_BAUD;
         s.rx_pin   <= 3'h7;
         s.rx_line  <= 1'b1;
      end
      else
         s <= next_s;
   end

   ////////////////////////////////////////////////////////////////////////
   // Outputs.
   assign wb_rsp.ack = s.ack;
   assign wb_rsp.dat = s.rdata;
   assign tx_oe      = s.tx_on || s.tx_st != TX_IDLE;
   assign tx_pin     = (s.tx_st == TX_IDLE) ? 1'b1 : s.tx_sh[0];

   // One request line for all enabled, unmasked events.
   assign irq_req = !irq_mask && ((s.empty && s.irq_en[3])
                                  || (s.done && s.irq_en[2])
                                  || ((s.full || s.ovr) && s.irq_en[1])
                                  || (s.idle && s.irq_en[0]));

endmodule : async_serial_transceiver

// ### hw/async_serial_map.svh
`ifndef ASYNC_SERIAL_MAP_SVH
`define ASYNC_SERIAL_MAP_SVH

// Register byte offsets on the bus.
`define OFS_FLAG      8'h00
`define OFS_DATA      8'h04
`define OFS_CTRL_ONE  8'h08
`define OFS_CTRL_TWO  8'h0c
`define OFS_BAUD      8'h10

// Flag register bit positions.
`define FLG_EMPTY     7
`define FLG_DONE      6
`define FLG_FULL      5
`define FLG_IDLE      4
`define FLG_OVERRUN   3
`define FLG_NOISE     2
`define FLG_FRAMING   1

// Control register one bit positions.
`define C1_RX_NINTH   7
`define C1_TX_NINTH   6
`define C1_WORD9      4

// Control register two bit positions.
`define C2_EMPTY_EN   7
`define C2_DONE_EN    6
`define C2_RX_EN      5
`define C2_IDLE_EN    4
`define C2_TX_ON      3
`define C2_RX_ON      2
`define C2_BREAK      0

// Baud register field positions.
`define BR_COARSE_LSB 6
`define BR_TX_LSB     3
`define BR_RX_LSB     0

// Reset values.
`define RST_EMPTY     1'b1
`define RST_DONE      1'b1
`define RST_BAUD      8'h00

// Coarse prescaler factors and oversampling timing.
`define COARSE_0      11'h001
`define COARSE_1      11'h003
`define COARSE_2      11'h004
`define COARSE_3      11'h00d
`define SUB_LAST      4'hf
`define SUB_SMP_A     4'h7
`define SUB_SMP_B     4'h8
`define SUB_DECIDE    4'h9

`endif

// ### hw/async_serial_pkg.sv
package async_serial_pkg;

   // Bus request from the master and answer to it.
   typedef struct packed {
      logic        cyc;
      logic        stb;
      logic        we;
      logic [7:0]  adr;
      logic [3:0]  sel;
      logic [31:0] dat;
   } wb_req_t;

   typedef struct packed {
      logic        ack;
      logic [31:0] dat;
   } wb_rsp_t;

   // Transmit sequencer states.
   typedef enum logic [3:0] {
      TX_IDLE = 4'b0001,
      TX_SEND = 4'b0010,
      TX_BRK  = 4'b0100,
      TX_MARK = 4'b1000
   } tx_state_t;

   // Receive sequencer states.
   typedef enum logic [1:0] {
      RX_HUNT = 2'b01,
      RX_BITS = 2'b10
   } rx_state_t;

   // Whole state of the transceiver.
   typedef struct packed {
      logic        ack;
      logic [31:0] rdata;
      logic        word9;
      logic        tx_ninth;
      logic        rx_ninth;
      logic [3:0]  irq_en;
      logic        tx_on;
      logic        rx_on;
      logic        brk;
      logic [7:0]  baud;
      logic        empty;
      logic        done;
      logic        full;
      logic        idle;
      logic        ovr;
      logic        noise;
      logic        framing;
      logic        tx_arm;
      logic        rx_arm;
      logic [7:0]  hold;
      logic        hold_valid;
      logic        idle_pend;
      tx_state_t   tx_st;
      logic [10:0] tx_sh;
      logic [3:0]  tx_bits;
      logic [3:0]  tx_sub;
      logic [10:0] tx_div;
      rx_state_t   rx_st;
      logic [2:0]  rx_pin;
      logic        rx_line;
      logic [10:0] rx_div;
      logic [3:0]  rx_sub;
      logic [3:0]  rx_idx;
      logic [8:0]  rx_sh;
      logic [1:0]  smp;
      logic        rx_noise;
      logic [8:0]  rx_hold;
      logic [7:0]  idle_cnt;
      logic        idle_arm;
   } state_t;

endpackage : async_serial_pkg

// ### verif/async_serial_properties.sv
`timescale 1ns/10ps

module async_serial_properties
(
   // Clock and reset.
   input wire logic                      clk_sys,
   input wire logic                      resetn,
   // Register bus and interrupt.
   input wire async_serial_pkg::wb_req_t wb_req,
   input wire async_serial_pkg::wb_rsp_t wb_rsp,
   input wire logic                      irq_mask,
   input wire logic                      irq_req,
   // Serial line.
   input wire logic                      serial_rx_pin,
   input wire logic                      tx_pin,
   input wire logic                      tx_oe
);
   import async_serial_pkg::*;

   logic [7:0]  low_run;
   logic [7:0]  high_run;
   logic [15:0] since_oe;

   ////////////////////////////////////////////////////////////////
   // Saturating run lengths of each line level and of pin ownership.
   always_ff @(posedge clk_sys or negedge resetn)
   begin
      if (!resetn)
      begin
         low_run  <= 8'h00;
         high_run <= 8'h00;
         since_oe <= 16'h0000;
      end
      else
      begin
         low_run  <= tx_pin ? 8'h00 : low_run + {7'h00, low_run != 8'hff};
         high_run <= !tx_pin ? 8'h00 : high_run + {7'h00, high_run != 8'hff};
         since_oe <= !tx_oe ? 16'h0000 : since_oe + {15'h0000, since_oe != 16'hffff};
      end
   end

   default clocking cb @(posedge clk_sys);
   endclocking
   default disable iff (!resetn);

   // Bus answers, interrupt gating and whole bit times on the line.
   a_ack_follows: assert property (wb_req.cyc && wb_req.stb && !wb_rsp.ack |=> wb_rsp.ack)
      else $error("bus request not answered");
   a_ack_pulse: assert property (wb_rsp.ack |=> !wb_rsp.ack)
      else $error("ack longer than one cycle");
   a_ack_cause: assert property ($rose(wb_rsp.ack) |-> $past(wb_req.cyc && wb_req.stb))
      else $error("ack without request");
   a_rdata_byte: assert property (wb_rsp.ack |-> wb_rsp.dat[31:8] == 24'h000000)
      else $error("read data above byte");
   a_irq_masked: assert property (irq_mask |-> !irq_req)
      else $error("interrupt while masked");
   a_start_whole: assert property ($rose(tx_pin) |-> low_run >= 8'h10)
      else $error("low level shorter than a bit");
   a_mark_whole: assert property ($fell(tx_pin) |-> high_run >= 8'h10)
      else $error("high level shorter than a bit");
   a_pin_idle: assert property (!tx_oe |-> tx_pin)
      else $error("pin low while not owned");
   a_idle_first: assert property ($fell(tx_pin) |-> since_oe >= 16'h00a0)
      else $error("start bit before idle frame");

   c_write: cover property (wb_rsp.ack && wb_req.we);
   c_start: cover property ($fell(tx_pin));
   c_irq: cover property (irq_req);
endmodule : async_serial_properties

bind async_serial_transceiver async_serial_properties u_props (.clk_sys(clk_sys),
   .resetn(resetn), .wb_req(wb_req), .wb_rsp(wb_rsp), .irq_mask(irq_mask),
   .irq_req(irq_req), .serial_rx_pin(serial_rx_pin), .tx_pin(tx_pin), .tx_oe(tx_oe));

// ### verif/serial_partner.sv
`timescale 1ns/10ps

module serial_partner
#(
   parameter int TX_BIT = 32,
   parameter int RX_BIT = 16
)
(
   // Clock.
   input  wire logic clk_sys,
   // Lines seen from the far end.
   input  wire logic tx_pin,
   output      logic serial_rx_pin
);
   int         rx_len = 8;
   int         frames = 0;
   logic [9:0] got    = 10'h000;
   logic [9:0] cap;

   initial serial_rx_pin <= 1'b1;

   ////////////////////////////////////////////////////////////////
   // Sends start, word LSB first and stop; optional glitch in bit 0.
   // The glitch lasts two cycles so that it passes the pin filter and hits one sample.
   task automatic send(input logic [8:0] w, input int n, input logic stop, input logic gl);
      logic b;
      for (int i = 0; i < n + 2; i++)
         for (int c = 0; c < RX_BIT; c++)
         begin
            @(posedge clk_sys);
            b = (i == 0) ? 1'b0 : (i > n) ? stop : w[i - 1];
            serial_rx_pin <= b ^ (gl && i == 1 && (c == 9 || c == 10));
         end
      @(posedge clk_sys);
      serial_rx_pin <= 1'b1;
   endtask : send

   // Samples each frame mid-bit; got holds stop level, ninth bit and byte.
   always
   begin
      @(negedge tx_pin);
      repeat (TX_BIT / 2) @(posedge clk_sys);
      if (tx_pin === 1'b0)
      begin
         for (int i = 0; i <= rx_len; i++)
         begin
            repeat (TX_BIT) @(posedge clk_sys);
            cap[i] = tx_pin;
         end
         got    = (rx_len == 8) ? {cap[8], 1'b0, cap[7:0]} : cap;
         frames = frames + 1;
      end
   end
endmodule : serial_partner

// ### verif/async_serial_transceiver_tb.sv
`timescale 1ns/10ps
`include "async_serial_map.svh"

module async_serial_transceiver_tb;
   import async_serial_pkg::*;

   logic       clk_sys;
   logic       resetn;
   wb_req_t    wb_req;
   wb_rsp_t    wb_rsp;
   logic       irq_mask;
   logic       irq_req;
   logic       serial_rx_pin;
   logic       tx_pin;
   logic       tx_oe;
   int         failures = 0;
   int         checks   = 0;
   int         n;
   logic [7:0] rd;

   async_serial_transceiver DUT (.clk_sys(clk_sys), .resetn(resetn), .wb_req(wb_req),
      .wb_rsp(wb_rsp), .irq_mask(irq_mask), .irq_req(irq_req),
      .serial_rx_pin(serial_rx_pin), .tx_pin(tx_pin), .tx_oe(tx_oe));

   serial_partner #(.TX_BIT(32), .RX_BIT(16)) partner (.clk_sys(clk_sys), .tx_pin(tx_pin),
      .serial_rx_pin(serial_rx_pin));

   // Free-running 50 MHz clock.
   initial
   begin
      clk_sys = 1'b0;
      forever #10 clk_sys = ~clk_sys;
   end

   ////////////////////////////////////////////////////////////////
   // Verdict and end of run.
   task automatic tally_and_finish;
      if (failures == 0 && checks > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask : tally_and_finish

   // Compares a ten-bit result.
   task automatic check(input logic [9:0] got, input logic [9:0] exp);
      checks++;
      if (got !== exp)
      begin
         failures++;
         $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : check

   // One classic Wishbone cycle, held until ack is sampled high.
   task automatic bus(input logic we, input logic [7:0] adr, input logic [7:0] wd,
                      output logic [7:0] q);
      int i;
      @(posedge clk_sys);
      wb_req <= '{cyc: 1'b1, stb: 1'b1, we: we, adr: adr, sel: 4'h1, dat: {24'h0, wd}};
      i = 0;
      do
      begin
         @(posedge clk_sys);
         i++;
      end
      while (wb_rsp.ack !== 1'b1 && i < 20);
      if (i >= 20)
      begin
         failures++;
         tally_and_finish();
      end
      else
      begin
         q = wb_rsp.dat[7:0];
         wb_req <= '0;
      end
   endtask : bus

   task automatic wr(input logic [7:0] adr, input logic [7:0] d);
      bus(1'b1, adr, d, rd);
   endtask : wr

   task automatic rdc(input logic [7:0] adr, input logic [7:0] mask, input logic [7:0] exp);
      bus(1'b0, adr, 8'h00, rd);
      check({2'h0, rd & mask}, {2'h0, exp});
   endtask : rdc

   // Waits, bounded, until the far end has captured k frames.
   task automatic wait_frames(input int k);
      for (int i = 0; i < 3000 && partner.frames < k; i++)
         @(posedge clk_sys);
      check(partner.frames[9:0], k[9:0]);
   endtask : wait_frames

   // Sends one character, two when k is above 1, checks flags, data and clearing, then drains the idle.
   task automatic rx_char(input logic [8:0] w, input int nb, input logic stop, input logic gl,
                          input int k, input logic [7:0] flags, input logic [7:0] data);
      int i;
      partner.send(w, nb, stop, gl);
      if (k > 1)
         partner.send(w ^ 9'h0ff, nb, stop, gl);
      i = 0;
      do
      begin
         bus(1'b0, `OFS_FLAG, 8'h00, rd);
         i++;
      end
      while (rd[`FLG_FULL] !== 1'b1 && i < 50);
      check({2'h0, rd & 8'h3e}, {2'h0, flags});
      check({9'h000, irq_req}, 10'h001);
      rdc(`OFS_CTRL_ONE, 8'h80, {w[8], 7'h00});
      rdc(`OFS_DATA, 8'hff, data);
      rdc(`OFS_FLAG, 8'h3e, 8'h00);
      repeat (250) @(posedge clk_sys);
      bus(1'b0, `OFS_FLAG, 8'h00, rd);
      bus(1'b0, `OFS_DATA, 8'h00, rd);
   endtask : rx_char

   ////////////////////////////////////////////////////////////////
   // Main sequence: transmit paths first, then the receiver.
   initial
   begin
      resetn   <= 1'b0;
      irq_mask <= 1'b1;
      wb_req   <= '0;
      repeat (4) @(posedge clk_sys);
      resetn <= 1'b1;
      repeat (3) @(posedge clk_sys);
      check({9'h000, tx_oe}, 10'h000);
      rdc(`OFS_FLAG, 8'hff, 8'hc0);
      rdc(`OFS_BAUD, 8'hff, 8'h00);
      rdc(8'h20, 8'hff, 8'h00);
      wr(`OFS_BAUD, 8'h08);
      wr(`OFS_CTRL_TWO, 8'h08);
      bus(1'b0, `OFS_FLAG, 8'h00, rd);
      check({9'h000, tx_oe}, 10'h001);
      wr(`OFS_DATA, 8'ha5);
      for (n = 0; n < 2000 && tx_pin !== 1'b0; n++)
         @(posedge clk_sys);
      check({9'h000, n >= 300}, 10'h001);
      bus(1'b0, `OFS_FLAG, 8'h00, rd);
      wr(`OFS_DATA, 8'h3c);
      rdc(`OFS_FLAG, 8'h80, 8'h00);
      wait_frames(1);
      check(partner.got, 10'h2a5);
      wait_frames(2);
      check(partner.got, 10'h23c);
      repeat (40) @(posedge clk_sys);
      rdc(`OFS_FLAG, 8'hc0, 8'hc0);
      irq_mask <= 1'b0;
      wr(`OFS_CTRL_TWO, 8'h48);
      @(posedge clk_sys);
      check({9'h000, irq_req}, 10'h001);
      irq_mask <= 1'b1;
      @(posedge clk_sys);
      check({9'h000, irq_req}, 10'h000);
      irq_mask <= 1'b0;
      wr(`OFS_CTRL_TWO, 8'h88);
      bus(1'b0, `OFS_FLAG, 8'h00, rd);
      wr(`OFS_DATA, 8'h55);
      rdc(`OFS_FLAG, 8'hc0, 8'h80);
      check({9'h000, irq_req}, 10'h001);
      wait_frames(3);
      check(partner.got, 10'h255);
      wr(`OFS_CTRL_TWO, 8'h08);
      wr(`OFS_CTRL_ONE, 8'h50);
      partner.rx_len = 9;
      bus(1'b0, `OFS_FLAG, 8'h00, rd);
      wr(`OFS_DATA, 8'h81);
      wait_frames(4);
      check(partner.got, 10'h381);
      repeat (40) @(posedge clk_sys);
      wr(`OFS_CTRL_ONE, 8'h00);
      partner.rx_len = 8;
      wr(`OFS_CTRL_TWO, 8'h09);
      wait_frames(5);
      check(partner.got, 10'h000);
      wr(`OFS_CTRL_TWO, 8'h08);
      for (n = 0; n < 1000 && tx_pin !== 1'b1; n++)
         @(posedge clk_sys);
      check({9'h000, n < 1000}, 10'h001);
      repeat (400) @(posedge clk_sys);
      bus(1'b0, `OFS_FLAG, 8'h00, rd);
      wr(`OFS_DATA, 8'h11);
      bus(1'b0, `OFS_FLAG, 8'h00, rd);
      wr(`OFS_DATA, 8'h22);
      wr(`OFS_CTRL_TWO, 8'h00);
      wr(`OFS_CTRL_TWO, 8'h08);
      repeat (1500) @(posedge clk_sys);
      check(partner.frames[9:0], 10'h006);
      check(partner.got, 10'h211);
      wr(`OFS_CTRL_TWO, 8'h1c);
      repeat (300) @(posedge clk_sys);
      check({9'h000, irq_req}, 10'h001);
      rdc(`OFS_FLAG, 8'h3e, 8'h30);
      rdc(`OFS_DATA, 8'hff, 8'hff);
      @(posedge clk_sys);
      check({9'h000, irq_req}, 10'h000);
      wr(`OFS_CTRL_TWO, 8'h2c);
      rx_char(9'h05a, 8, 1'b1, 1'b0, 1, 8'h20, 8'h5a);
      rx_char(9'h0c3, 8, 1'b1, 1'b1, 1, 8'h24, 8'hc3);
      rx_char(9'h000, 8, 1'b0, 1'b0, 1, 8'h22, 8'h00);
      rx_char(9'h069, 8, 1'b1, 1'b0, 2, 8'h28, 8'h69);
      wr(`OFS_CTRL_ONE, 8'h10);
      rx_char(9'h1a5, 9, 1'b1, 1'b0, 1, 8'h20, 8'ha5);
      rdc(`OFS_CTRL_ONE, 8'h80, 8'h80);
      tally_and_finish();
   end
endmodule : async_serial_transceiver_tb
